/* File: stp_params.svh */
`ifndef STP_PARAMS_SVH
`define STP_PARAMS_SVH

// Consecutive TMS-high test clocks that force the logic-reset state
`define STP_RESET_TMS_CYCLES 3'h5
`define STP_TMS_CNT_W        3

// Instruction register
`define STP_IR_W             4
`define STP_IR_CAPTURE       4'h1
`define STP_INS_IDCODE       4'h1
`define STP_INS_PROBE        4'h2
`define STP_INS_BYPASS       4'hF

// Data shift register
`define STP_DR_W             32
`define STP_DR_LEN_W         6
`define STP_DR_LEN_ID        6'h20
`define STP_DR_LEN_BYPASS    6'h01

// Probe word: per pin one field, enable bit lowest, select above it
`define STP_PRB_N            2
`define STP_PRB_EN_BIT       0
`define STP_PRB_SEL_LSB      1

// Shared scan pins, index into the user side vectors
`define STP_IO_N             3
`define STP_IO_TCK           0
`define STP_IO_TDI           1
`define STP_IO_TDO           2

// Bits of the pin synchroniser in the reference domain
`define STP_SY_W             8
`define STP_SY_PRB_LSB       3
`define STP_SY_TMS           5
`define STP_SY_CFG           6
`define STP_SY_FUSE          7

// Reference cycles after reset before the straps are caught
`define STP_STRAP_CNT_W      2
`define STP_STRAP_WAIT       2'h2

`endif

/* File: stp_pkg.sv */
package stp_pkg;

  // Boundary-scan controller states, one-hot
  typedef enum logic [15:0] {
    STP_TLR = 16'h0001,
    STP_RTI = 16'h0002,
    STP_SDS = 16'h0004,
    STP_CDR = 16'h0008,
    STP_SDR = 16'h0010,
    STP_E1D = 16'h0020,
    STP_PD  = 16'h0040,
    STP_E2D = 16'h0080,
    STP_UDR = 16'h0100,
    STP_SIS = 16'h0200,
    STP_CIR = 16'h0400,
    STP_SIR = 16'h0800,
    STP_E1I = 16'h1000,
    STP_PI  = 16'h2000,
    STP_E2I = 16'h4000,
    STP_UIR = 16'h8000
  } stp_tap_type;

  // Test port mode, fixed by a strap
  typedef enum logic [1:0] {
    STP_MODE_FLEX = 2'h1,
    STP_MODE_DED  = 2'h2
  } stp_mode_type;

endpackage

/* File: stp_probe.sv */
`timescale 1ns/10ps
`include "stp_params.svh"

// Probe pin drivers: live node or ordinary user I/O
module stp_probe
  import stp_pkg::*;
#(
  parameter int NODE_N = 16,
  parameter int SEL_W  = 4
) (
  input  wire logic                            ref_clk,
  input  wire logic                            reset,
  input  wire logic [NODE_N-1:0]               nodes,
  input  wire logic [`STP_PRB_N*(SEL_W+1)-1:0] cfg,
  input  wire logic                            fuse,
  input  wire logic [`STP_PRB_N-1:0]           user_out,
  input  wire logic [`STP_PRB_N-1:0]           user_oe,
  output logic      [`STP_PRB_N-1:0]           pin_out,
  output logic      [`STP_PRB_N-1:0]           pin_oe
);

  typedef struct packed {
    logic [`STP_PRB_N-1:0] out;
    logic [`STP_PRB_N-1:0] oe;
  } stp_probe_type;

  stp_probe_type st_q, st_d;
  logic [`STP_PRB_N-1:0] nx_out;
  logic [`STP_PRB_N-1:0] nx_oe;

  if (NODE_N < 1 || NODE_N > (1 << SEL_W)) begin : g_chk
    $error("stp_probe: SEL_W cannot address NODE_N nodes");
  end

  // Per pin: a blown fuse wins over any enable left in the probe word
  for (genvar p = 0; p < `STP_PRB_N; p++) begin : g_pin
    localparam int BASE = p * (SEL_W + 1);
    logic [SEL_W-1:0] sel;
    logic             en;
    assign sel = cfg[BASE + `STP_PRB_SEL_LSB +: SEL_W];
    assign en  = cfg[BASE + `STP_PRB_EN_BIT] & ~fuse;
    // Out-of-range selects read as low rather than wrapping
    assign nx_out[p] = en ? ((32'(sel) < NODE_N) ? nodes[sel] : 1'b0)
                          : user_out[p];
    assign nx_oe[p]  = en | user_oe[p];
  end

  // Register the pin drive so the pads see clean edges
  always_comb begin
    st_d     = st_q;
    st_d.out = nx_out;
    st_d.oe  = nx_oe;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_out = st_q.out;
  assign pin_oe  = st_q.oe;

endmodule // stp_probe

/* File: stp_sync.sv */
`timescale 1ns/10ps
`include "stp_params.svh"

// Two-flop level synchroniser; only the second stage is visible
module stp_sync
  import stp_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } stp_sync_type;

  stp_sync_type st_q, st_d;

  if (W < 1) begin : g_chk
    $error("stp_sync: W must be at least 1");
  end

  // First stage feeds the second and nothing else
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule // stp_sync

/* File: stp_tester.sv */
`timescale 1ns/10ps

// Scan tester; TCK stands low outside frames, idle TDI toggles
module stp_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // Idle levels at time zero
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One TCK period; TDO is taken just before the rising edge
  task automatic tick(input logic t, input logic d, output logic o);
    tms = t;
    tdi = d;
    #15;
    o = tdo;
    tck = 1'b1;
    #15;
    tck = 1'b0;
  endtask

  // TMS low long enough for both domains, then settle in idle
  task automatic grab();
    logic o;
    tms = 1'b0;
    #150;
    repeat (5) tick(1'b0, ~tdi, o);
  endtask

  // TMS high for more than five clocks hands the pins back in flexible mode
  task automatic hand_back();
    logic o;
    repeat (9) tick(1'b1, ~tdi, o);
  endtask

  // Idle to shift, lsb first, then update and back to idle
  task automatic shift(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    logic o;
    dout = 32'h0;
    tick(1'b1, ~tdi, o);
    if (ir)
      tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
    tick(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
  endtask
endmodule // stp_tester

/* File: stp_top.sv */
`timescale 1ns/10ps
`include "stp_params.svh"

module stp_top
  import stp_pkg::*;
#(
  parameter int          NODE_N  = 16,
  parameter int          SEL_W   = 4,
  parameter logic [31:0] ID_CODE = 32'h0A5A_0001 // Arbitrary value
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   tck_pin_in,
  output logic                        tck_pin_out,
  output logic                        tck_pin_oe,
  input  wire logic                   tdi_pin_in,
  output logic                        tdi_pin_out,
  output logic                        tdi_pin_oe,
  input  wire logic                   tdo_pin_in,
  output logic                        tdo_pin_out,
  output logic                        tdo_pin_oe,
  input  wire logic                   tms_pin,
  input  wire logic                   probe_pin_a_in,
  output logic                        probe_pin_a_out,
  output logic                        probe_pin_a_oe,
  input  wire logic                   probe_pin_b_in,
  output logic                        probe_pin_b_out,
  output logic                        probe_pin_b_oe,
  input  wire logic                   cfg_dedicated,
  input  wire logic                   probe_fuse,
  input  wire logic [NODE_N-1:0]      probe_nodes,
  output logic      [`STP_IO_N-1:0]   user_io_in,
  input  wire logic [`STP_IO_N-1:0]   user_io_out,
  input  wire logic [`STP_IO_N-1:0]   user_io_oe,
  output logic      [`STP_PRB_N-1:0]  user_prb_in,
  input  wire logic [`STP_PRB_N-1:0]  user_prb_out,
  input  wire logic [`STP_PRB_N-1:0]  user_prb_oe,
  output logic                        scan_active
);

  localparam int PW = `STP_PRB_N * (SEL_W + 1);

  if (PW > `STP_DR_W) begin : g_chk
    $error("stp_top: probe word wider than the data shift register");
  end

  // Test clock domain state
  typedef struct packed {
    stp_tap_type                tap;
    logic [`STP_IR_W-1:0]       ir;
    logic [`STP_IR_W-1:0]       ir_sr;
    logic [`STP_DR_W-1:0]       sr;
    logic [`STP_TMS_CNT_W-1:0]  tms_cnt;
    logic [PW-1:0]              cfg;
    logic                       tlr_tog;
    logic                       upd_tog;
  } stp_tck_type;

  // Reference clock domain state
  typedef struct packed {
    logic [`STP_STRAP_CNT_W-1:0] strap_cnt;
    logic                        strap_done;
    stp_mode_type                mode;
    logic                        fuse;
    logic                        own;
    logic                        tlr_seen;
    logic                        upd_seen;
    logic [PW-1:0]               prb_cfg;
    logic [`STP_IO_N-1:0]        io_out;
    logic [`STP_IO_N-1:0]        io_oe;
    logic [`STP_IO_N-1:0]        io_in;
    logic [`STP_PRB_N-1:0]       prb_in;
  } stp_ref_type;

  stp_tck_type t_q, t_d;
  stp_ref_type r_q, r_d;
  logic        tdo_q;

  logic [`STP_SY_W-1:0]     pin_s;
  logic [1:0]               tck_s;
  logic [1:0]               tog_s;
  logic                     run;
  logic [`STP_DR_LEN_W-1:0] dr_len;
  logic                     tlr_evt;
  logic                     upd_evt;
  logic [`STP_PRB_N-1:0]    prb_out;
  logic [`STP_PRB_N-1:0]    prb_oe;

  // Controller next state per IEEE 1149.1
  function automatic stp_tap_type tap_next(stp_tap_type s, logic tms);
    stp_tap_type n;
    n = STP_TLR;
    unique case (s)
      STP_TLR: n = tms ? STP_TLR : STP_RTI;
      STP_RTI: n = tms ? STP_SDS : STP_RTI;
      STP_SDS: n = tms ? STP_SIS : STP_CDR;
      STP_CDR: n = tms ? STP_E1D : STP_SDR;
      STP_SDR: n = tms ? STP_E1D : STP_SDR;
      STP_E1D: n = tms ? STP_UDR : STP_PD;
      STP_PD:  n = tms ? STP_E2D : STP_PD;
      STP_E2D: n = tms ? STP_UDR : STP_SDR;
      STP_UDR: n = tms ? STP_SDS : STP_RTI;
      STP_SIS: n = tms ? STP_TLR : STP_CIR;
      STP_CIR: n = tms ? STP_E1I : STP_SIR;
      STP_SIR: n = tms ? STP_E1I : STP_SIR;
      STP_E1I: n = tms ? STP_UIR : STP_PI;
      STP_PI:  n = tms ? STP_E2I : STP_PI;
      STP_E2I: n = tms ? STP_UIR : STP_SIR;
      STP_UIR: n = tms ? STP_SDS : STP_RTI;
      default: n = STP_TLR; // A corrupted one-hot code recovers here
    endcase
    return n;
  endfunction

  // Pins and straps into the reference domain
  stp_sync #(
    .W (`STP_SY_W)
  ) u_sync_pin (
    .clk   (ref_clk),
    .reset (reset),
    .d     ({probe_fuse, cfg_dedicated, tms_pin, probe_pin_b_in,
             probe_pin_a_in, tdo_pin_in, tdi_pin_in, tck_pin_in}),
    .q     (pin_s)
  );

  // Mode and ownership levels into the test clock domain
  stp_sync #(
    .W (2)
  ) u_sync_tck (
    .clk   (tck_pin_in),
    .reset (reset),
    .d     ({r_q.mode[1], r_q.own}),
    .q     (tck_s)
  );

  // Logic-reset and probe-update toggles back to the reference domain
  stp_sync #(
    .W (2)
  ) u_sync_tog (
    .clk   (ref_clk),
    .reset (reset),
    .d     ({t_q.upd_tog, t_q.tlr_tog}),
    .q     (tog_s)
  );

  // Data register length follows the current instruction
  always_comb begin
    unique case (t_q.ir)
      `STP_INS_IDCODE: dr_len = `STP_DR_LEN_ID;
      `STP_INS_PROBE:  dr_len = `STP_DR_LEN_W'(PW);
      default:         dr_len = `STP_DR_LEN_BYPASS;
    endcase
  end

  // The controller only runs while it owns the pins; otherwise TCK is
  // user traffic and must not walk the state machine
  assign run = tck_s[0] | tck_s[1];

  always_comb begin
    t_d = t_q;
    if (!run) begin
      t_d.tap     = STP_TLR;
      t_d.ir      = `STP_INS_IDCODE;
      t_d.tms_cnt = '0;
    end else begin
      t_d.tap = tap_next(t_q.tap, tms_pin);
      if (!tms_pin) begin
        t_d.tms_cnt = '0;
      end else if (t_q.tms_cnt != `STP_RESET_TMS_CYCLES) begin
        t_d.tms_cnt = `STP_TMS_CNT_W'(t_q.tms_cnt + 1'b1);
      end
      // Backstop: the fifth high TMS edge lands in logic-reset regardless
      if (tms_pin && t_q.tms_cnt == `STP_RESET_TMS_CYCLES - 3'h1) begin
        t_d.tap = STP_TLR;
      end
      // Announce arrival at logic-reset to the pin owner
      if (t_d.tap == STP_TLR && t_q.tap != STP_TLR) begin
        t_d.tlr_tog = ~t_q.tlr_tog;
      end
      if (t_q.tap == STP_TLR) begin
        t_d.ir = `STP_INS_IDCODE;
      end
      if (t_q.tap == STP_CIR) begin
        t_d.ir_sr = `STP_IR_CAPTURE;
      end
      if (t_q.tap == STP_SIR) begin
        t_d.ir_sr = {tdi_pin_in, t_q.ir_sr[`STP_IR_W-1:1]};
      end
      if (t_q.tap == STP_UIR) begin
        t_d.ir = t_q.ir_sr;
      end
      if (t_q.tap == STP_CDR) begin
        unique case (t_q.ir)
          `STP_INS_IDCODE: t_d.sr = ID_CODE;
          `STP_INS_PROBE:  t_d.sr = `STP_DR_W'(t_q.cfg);
          default:         t_d.sr = '0;
        endcase
      end
      if (t_q.tap == STP_SDR) begin
        t_d.sr             = t_q.sr >> 1;
        t_d.sr[dr_len - 1] = tdi_pin_in;
      end
      // Probe word changes only on update, so it is stable for crossing
      if (t_q.tap == STP_UDR && t_q.ir == `STP_INS_PROBE) begin
        t_d.cfg     = t_q.sr[PW-1:0];
        t_d.upd_tog = ~t_q.upd_tog;
      end
    end
  end

  always_ff @(posedge tck_pin_in or posedge reset) begin
    if (reset) begin
      t_q <= '{tap: STP_TLR, ir: `STP_INS_IDCODE, default: '0};
    end else begin
      t_q <= t_d;
    end
  end

  // Scan output launched on the falling test clock edge
  always_ff @(negedge tck_pin_in or posedge reset) begin
    if (reset) begin
      tdo_q <= 1'b0;
    end else if (t_q.tap == STP_SIR) begin
      tdo_q <= t_q.ir_sr[0];
    end else if (t_q.tap == STP_SDR) begin
      tdo_q <= t_q.sr[0];
    end
  end

  assign tlr_evt = tog_s[0] ^ r_q.tlr_seen;
  assign upd_evt = tog_s[1] ^ r_q.upd_seen;

  // Straps, pin ownership and the user side of the shared pins
  always_comb begin
    r_d          = r_q;
    r_d.tlr_seen = tog_s[0];
    r_d.upd_seen = tog_s[1];
    // Straps are caught once, after the synchroniser has filled
    if (!r_q.strap_done) begin
      r_d.strap_cnt = `STP_STRAP_CNT_W'(r_q.strap_cnt + 1'b1);
      if (r_q.strap_cnt == `STP_STRAP_WAIT) begin
        r_d.strap_done = 1'b1;
        r_d.fuse       = pin_s[`STP_SY_FUSE];
        r_d.mode       = pin_s[`STP_SY_CFG] ? STP_MODE_DED
                                            : STP_MODE_FLEX;
      end
    end
    if (upd_evt) begin
      r_d.prb_cfg = t_q.cfg;
    end
    if (r_q.mode == STP_MODE_DED) begin
      r_d.own = 1'b1;
    end else if (r_q.strap_done) begin
      if (tlr_evt) begin
        r_d.own = 1'b0;
      end
      // A fresh TMS low wins over a release in the same cycle
      if (!pin_s[`STP_SY_TMS]) begin
        r_d.own = 1'b1;
      end
    end
    r_d.io_out = user_io_out;
    r_d.io_oe  = user_io_oe;
    r_d.io_in  = pin_s[`STP_IO_N-1:0];
    if (r_d.own) begin
      // TCK and TDI become inputs, TDO is driven by the scan logic
      r_d.io_oe             = '0;
      r_d.io_oe[`STP_IO_TDO] = 1'b1;
      r_d.io_in             = '0;
    end
    r_d.prb_in = pin_s[`STP_SY_PRB_LSB +: `STP_PRB_N];
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      r_q <= '{mode: STP_MODE_FLEX, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // Probe pin drivers
  stp_probe #(
    .NODE_N (NODE_N),
    .SEL_W  (SEL_W)
  ) u_probe (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .nodes    (probe_nodes),
    .cfg      (r_q.prb_cfg),
    .fuse     (r_q.fuse),
    .user_out (user_prb_out),
    .user_oe  (user_prb_oe),
    .pin_out  (prb_out),
    .pin_oe   (prb_oe)
  );

  assign tck_pin_out     = r_q.io_out[`STP_IO_TCK];
  assign tck_pin_oe      = r_q.io_oe[`STP_IO_TCK];
  assign tdi_pin_out     = r_q.io_out[`STP_IO_TDI];
  assign tdi_pin_oe      = r_q.io_oe[`STP_IO_TDI];
  // Two flops, one per owner; the select itself is a flop as well
  assign tdo_pin_out     = r_q.own ? tdo_q : r_q.io_out[`STP_IO_TDO];
  assign tdo_pin_oe      = r_q.io_oe[`STP_IO_TDO];
  assign probe_pin_a_out = prb_out[0];
  assign probe_pin_a_oe  = prb_oe[0];
  assign probe_pin_b_out = prb_out[1];
  assign probe_pin_b_oe  = prb_oe[1];
  assign user_io_in      = r_q.io_in;
  assign user_prb_in     = r_q.prb_in;
  assign scan_active     = r_q.own;

endmodule // stp_top

/* File: stp_top_chk.sv */
`timescale 1ns/10ps
`include "stp_params.svh"

// Port-level checks of pin ownership and of the probe fuse
module stp_top_chk (
  input wire logic                  ref_clk,
  input wire logic                  reset,
  input wire logic                  tck_pin_in,
  input wire logic                  tms_pin,
  input wire logic                  cfg_dedicated,
  input wire logic                  probe_fuse,
  input wire logic                  tck_pin_oe,
  input wire logic                  tdi_pin_oe,
  input wire logic                  tdo_pin_oe,
  input wire logic                  probe_pin_a_out,
  input wire logic                  probe_pin_a_oe,
  input wire logic                  probe_pin_b_out,
  input wire logic                  probe_pin_b_oe,
  input wire logic [`STP_IO_N-1:0]  user_io_in,
  input wire logic [`STP_IO_N-1:0]  user_io_oe,
  input wire logic [`STP_PRB_N-1:0] user_prb_out,
  input wire logic [`STP_PRB_N-1:0] user_prb_oe,
  input wire logic                  scan_active
);
  logic [3:0] up_q;
  logic [3:0] hi_q;
  logic       run;

  // Age since reset and length of the TMS-high run, both saturating
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      up_q <= 4'h0;
      hi_q <= 4'h0;
    end else begin
      up_q <= (up_q == 4'hF) ? up_q : up_q + 4'h1;
      hi_q <= !tms_pin ? 4'h0 : ((hi_q == 4'hF) ? hi_q : hi_q + 4'h1);
    end
  end
  // Straps are long caught once the age saturates
  assign run = (up_q == 4'hF);

  a_owned_pin_dirs: assert property (
    @(posedge ref_clk) disable iff (reset)
    scan_active |-> !tck_pin_oe && !tdi_pin_oe && tdo_pin_oe
  ) else $error("scan pins not turned to scan use");
  a_owned_user_zero: assert property (
    @(posedge ref_clk) disable iff (reset)
    scan_active && $past(scan_active) |-> !(|user_io_in)
  ) else $error("user sees shared pads while scanning");
  a_enter_three: assert property (
    @(posedge ref_clk) disable iff (reset)
    (run && !cfg_dedicated && !tms_pin)[*4] |-> scan_active
  ) else $error("TMS low did not take the pins in time");
  a_hold_owned: assert property (
    @(posedge ref_clk) disable iff (reset)
    $fell(scan_active) |-> $past(hi_q, 3) >= 4'h3
  ) else $error("pins released without a TMS-high run");
  a_tlr_five: assert property (
    @(posedge tck_pin_in) disable iff (reset)
    (scan_active && !cfg_dedicated && tms_pin)[*5] ##1 tms_pin[*4]
      |-> !scan_active
  ) else $error("five TMS-high clocks did not release pins");
  a_user_follow: assert property (
    @(posedge ref_clk) disable iff (reset)
    run && !scan_active && !$past(scan_active)
      |-> {tdo_pin_oe, tdi_pin_oe, tck_pin_oe} == $past(user_io_oe)
  ) else $error("released pads do not follow user enables");
  a_ded_owned: assert property (
    @(posedge ref_clk) disable iff (reset)
    run && cfg_dedicated |-> scan_active
  ) else $error("dedicated mode gave the pins away");
  a_fuse_pin_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    run && probe_fuse |-> probe_pin_a_oe == $past(user_prb_oe[0]) &&
      (!probe_pin_a_oe || probe_pin_a_out == $past(user_prb_out[0]))
  ) else $error("probe a drives a node with fuse blown");
  a_fuse_pin_b: assert property (
    @(posedge ref_clk) disable iff (reset)
    run && probe_fuse |-> probe_pin_b_oe == $past(user_prb_oe[1]) &&
      (!probe_pin_b_oe || probe_pin_b_out == $past(user_prb_out[1]))
  ) else $error("probe b drives a node with fuse blown");

  // Main scenarios reached
  c_grab: cover property (@(posedge ref_clk) $rose(scan_active));
  c_release: cover property (@(posedge ref_clk) $fell(scan_active));
  c_probe: cover property (@(posedge ref_clk) $rose(probe_pin_a_oe));
endmodule // stp_top_chk

bind stp_top stp_top_chk i_stp_top_chk (
  .ref_clk(ref_clk), .reset(reset), .tck_pin_in(tck_pin_in),
  .tms_pin(tms_pin), .cfg_dedicated(cfg_dedicated),
  .probe_fuse(probe_fuse), .tck_pin_oe(tck_pin_oe),
  .tdi_pin_oe(tdi_pin_oe), .tdo_pin_oe(tdo_pin_oe),
  .probe_pin_a_out(probe_pin_a_out), .probe_pin_a_oe(probe_pin_a_oe),
  .probe_pin_b_out(probe_pin_b_out), .probe_pin_b_oe(probe_pin_b_oe),
  .user_io_in(user_io_in), .user_io_oe(user_io_oe),
  .user_prb_out(user_prb_out), .user_prb_oe(user_prb_oe),
  .scan_active(scan_active)
);

/* File: stp_top_test.sv */
`timescale 1ns/10ps

// Bench for the shared test pins and the probe pads
module stp_top_test;
  localparam logic [31:0] ID = 32'h1357_9BDF; // Arbitrary value
  logic        ref_clk, reset, cfg_dedicated, probe_fuse, ext_tdo;
  logic        tck_o, tck_e, tdi_o, tdi_e, tdo_o, tdo_e, scan_active;
  logic        pa_o, pa_e, pb_o, pb_e;
  logic [15:0] probe_nodes;
  logic [2:0]  user_io_out, user_io_oe, user_io_in;
  logic [1:0]  user_prb_out, user_prb_oe, user_prb_in;
  logic [3:0]  sa, sb;
  logic [31:0] got, din;
  wire logic   t_tck, t_tms, t_tdi, tck_pad, tdi_pad, tdo_pad;
  int          miscompares, num_checks;

  // Pads resolve from the design's enables and the far parties
  assign tck_pad = tck_e ? tck_o : t_tck;
  assign tdi_pad = tdi_e ? tdi_o : t_tdi;
  assign tdo_pad = tdo_e ? tdo_o : ext_tdo;

  stp_top #(.NODE_N(16), .SEL_W(4), .ID_CODE(ID)) i_stp_top (
    .ref_clk(ref_clk), .reset(reset), .tck_pin_in(tck_pad),
    .tck_pin_out(tck_o), .tck_pin_oe(tck_e), .tdi_pin_in(tdi_pad),
    .tdi_pin_out(tdi_o), .tdi_pin_oe(tdi_e), .tdo_pin_in(tdo_pad),
    .tdo_pin_out(tdo_o), .tdo_pin_oe(tdo_e), .tms_pin(t_tms),
    .probe_pin_a_in(pa_e ? pa_o : ext_tdo), .probe_pin_a_out(pa_o),
    .probe_pin_a_oe(pa_e), .probe_pin_b_in(pb_e ? pb_o : ~ext_tdo),
    .probe_pin_b_out(pb_o), .probe_pin_b_oe(pb_e),
    .cfg_dedicated(cfg_dedicated), .probe_fuse(probe_fuse),
    .probe_nodes(probe_nodes), .user_io_in(user_io_in),
    .user_io_out(user_io_out), .user_io_oe(user_io_oe),
    .user_prb_in(user_prb_in), .user_prb_out(user_prb_out),
    .user_prb_oe(user_prb_oe), .scan_active(scan_active));

  stp_tester i_stp_tester (.tck(t_tck), .tms(t_tms), .tdi(t_tdi),
                           .tdo(tdo_pad));

  // Reference clock, 25 ns
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Probe word: pin a field low, pin b above, enable lowest in each
  function automatic logic [31:0] pword(input logic [3:0] a, b,
                                        input logic en);
    return {22'h0, b, en, a, en};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, act);
    num_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, act);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Straps change only under reset; a TCK edge lands inside it
  task automatic do_reset(input logic ded, input logic fuse);
    logic o;
    reset = 1'b1;
    cfg_dedicated = ded;
    probe_fuse = fuse;
    i_stp_tester.tick(1'b1, 1'b0, o);
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    repeat (20) @(negedge ref_clk);
  endtask

  // Probe select through the scan port, then wait for the ref side
  task automatic set_probe(input logic [3:0] a, b, input logic en);
    i_stp_tester.shift(1'b1, 4, 32'h2, got);
    i_stp_tester.shift(1'b0, 10, pword(a, b, en), got);
    repeat (8) @(negedge ref_clk);
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    user_io_out = 3'h0;
    user_io_oe = 3'h0;
    user_prb_out = 2'h0;
    user_prb_oe = 2'h0;
    probe_nodes = 16'h0;
    ext_tdo = 1'b0;
    void'($urandom(3410));
    do_reset(1'b0, 1'b0);
    i_stp_tester.grab();
    check("scan_active", 32'h1, scan_active);
    i_stp_tester.shift(1'b0, 32, 32'h0, got);
    check("idcode", ID, got);
    // TMS high with TCK still must not give the pins back
    i_stp_tester.tms = 1'b1;
    repeat (8) @(negedge ref_clk);
    check("held", 32'h1, scan_active);
    i_stp_tester.shift(1'b1, 4, 32'hF, got);
    check("ir capture", 32'h1, got);
    din = $urandom;
    i_stp_tester.shift(1'b0, 8, din, got);
    check("bypass", {24'h0, din[6:0], 1'b0}, got);
    for (int k = 0; k < 4; k++) begin
      sa = (k == 0) ? 4'h0 : 4'($urandom);
      sb = (k == 0) ? 4'hF : 4'($urandom);
      set_probe(sa, sb, 1'b1);
      repeat (3) begin
        probe_nodes = 16'($urandom);
        repeat (4) @(negedge ref_clk);
        check("probe a", {1'b1, probe_nodes[sa]}, {pa_e, pa_o});
        check("probe b", {1'b1, probe_nodes[sb]}, {pb_e, pb_o});
      end
    end
    set_probe(4'h0, 4'h0, 1'b0);
    repeat (4) begin
      user_prb_out = 2'($urandom);
      user_prb_oe = 2'($urandom);
      // Pad drive takes one edge, the way back three more
      repeat (5) @(negedge ref_clk);
      check("probe user oe", user_prb_oe, {pb_e, pa_e});
      check("probe user out", user_prb_out, {pb_o, pa_o});
      check("probe pad in", {user_prb_oe[1] ? user_prb_out[1] : ~ext_tdo,
        user_prb_oe[0] ? user_prb_out[0] : ext_tdo}, user_prb_in);
    end
    i_stp_tester.hand_back();
    repeat (6) @(negedge ref_clk);
    check("released", 32'h0, scan_active);
    repeat (4) begin
      user_io_out = 3'($urandom);
      user_io_oe = 3'($urandom);
      ext_tdo = 1'($urandom);
      repeat (6) @(negedge ref_clk);
      check("user io in", {user_io_oe[2] ? user_io_out[2] : ext_tdo,
        user_io_oe[1] ? user_io_out[1] : t_tdi,
        user_io_oe[0] ? user_io_out[0] : t_tck}, user_io_in);
    end
    user_io_oe = 3'h0;
    user_prb_oe = 2'h0;
    // Nodes all high, user drive low: a leaking node would show
    user_prb_out = 2'h0;
    probe_nodes = 16'hFFFF;
    do_reset(1'b1, 1'b0);
    check("dedicated own", 32'h1, scan_active);
    i_stp_tester.grab();
    i_stp_tester.shift(1'b0, 32, 32'h0, got);
    check("dedicated id", ID, got);
    i_stp_tester.hand_back();
    repeat (6) @(negedge ref_clk);
    check("dedicated kept", 32'h1, scan_active);
    do_reset(1'b0, 1'b1);
    i_stp_tester.grab();
    set_probe(4'h3, 4'h5, 1'b1);
    check("fuse oe", 32'h0, {pb_e, pa_e});
    check("fuse out", 32'h0, {pb_o, pa_o});
    tally_and_finish();
  end
endmodule // stp_top_test
